/* File: card_host_irq_source.sv */
// Raw interrupt flags, mask and clear registers of the card host controller, APB slave.
// Assumes event inputs are one-cycle pulses on sys_clk_in; card pins are asynchronous.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - read-only raw flags at zero, reset zero
// - bit 19 shows live line 3
// - card interrupt follows card, not clearable
// - bit 17 set on transfer done
// - bit 16 set on data CRC failure
// - bit 15 set on response captured
// - bit 14 set on response CRC failure
// - bit 13 while idle and line low
// - bit 12 while idle and line high
// - bit 11 set on command sent
// - bit 10 set when busy ends
// - bit 9 card-side transmit FIFO error
// - bit 8 card-side receive FIFO error
// - bit 7 bus-side receive FIFO error
// - bit 6 bus overrun or width change
// - word write off lane zero misaligned
// - per-bit mask, one suppresses, reset ones
// - write one to clear register clears
module card_host_irq_source
	import card_irq_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Card pins, asynchronous
	input wire logic card_data_line_three_in,
	input wire logic card_irq_level_in,
	// Controller events, one-cycle pulses
	input wire logic data_done_in,
	input wire logic data_crc_fail_in,
	input wire logic resp_ready_in,
	input wire logic resp_crc_fail_in,
	input wire logic cmd_sent_in,
	input wire logic busy_end_in,
	input wire logic tx_card_err_in,
	input wire logic rx_card_err_in,
	input wire logic rx_bus_err_in,
	input wire logic tx_bus_overrun_in,
	// Bus-side transmit FIFO write, with access size
	input wire logic tx_fifo_write_in,
	input wire logic [1:0] tx_fifo_size_in,
	// Data engine state
	input wire logic data_idle_in,
	// Interrupt
	output logic irq_out
);
	card_irq_event_if events();

	logic [1:0] pin_sync;
	logic line3_level;
	logic card_irq_level;
	logic [18:0] flags;
	logic [18:0] mask;
	logic [1:0] last_size;
	logic size_seen;
	logic [1:0] byte_lane;
	logic [18:0] next_flags;
	logic [31:0] next_prdata;
	logic width_change;
	logic lane_misaligned;
	logic bus_push_err;
	logic [1:0] size_bytes;

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] offset);
		hit = (addr == offset);
	endfunction

	// Bytes a bus write moves, modulo four; a word adds zero and leaves the two-bit lane where it was
	function automatic logic [1:0] lane_step(input logic [1:0] size);
		case (size)
			SIZE_BYTE: lane_step = 2'h1;
			SIZE_HALF: lane_step = 2'h2;
			default: lane_step = 2'h0;
		endcase
	endfunction

	// The flag vector layout is fixed by the bit positions below
	if (FLAG_W != BIT_LINE3 + 1) begin : g_bad_flag_w
		$error("card_host_irq_source: FLAG_W must put the line level on the top bit");
	end
	if (MASK_W != BIT_CARD_IRQ + 1) begin : g_bad_mask_w
		$error("card_host_irq_source: MASK_W must cover every maskable source");
	end
	if (ADDR_W < 4) begin : g_bad_addr_w
		$error("card_host_irq_source: ADDR_W too narrow for the register map");
	end

	wire access_phase = psel_in & penable_in;
	wire wr_access = access_phase & pwrite_in;
	wire rd_access = access_phase & ~pwrite_in;
	wire hit_flags = hit(paddr_in, RAW_FLAGS_OFFSET);
	wire hit_mask = hit(paddr_in, IRQ_MASK_OFFSET);
	wire hit_clear = hit(paddr_in, IRQ_CLEAR_OFFSET);
	wire hit_any = hit_flags | hit_mask | hit_clear;
	wire [18:0] clear_req = (wr_access & hit_clear) ? pwdata_in[18:0] : 19'h00000;

	card_irq_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({card_irq_level_in, card_data_line_three_in}),
		.sync_out(pin_sync)
	);

	assign line3_level = pin_sync[0];
	assign card_irq_level = pin_sync[1];

	assign width_change = tx_fifo_write_in & size_seen & (tx_fifo_size_in != last_size);
	assign lane_misaligned = tx_fifo_write_in & (tx_fifo_size_in == SIZE_WORD)
		& (byte_lane != LANE_ZERO);
	assign bus_push_err = tx_bus_overrun_in | width_change | lane_misaligned;

	assign size_bytes = lane_step(tx_fifo_size_in);

	// Sources are gathered once so the flag logic sees one vector
	always_comb begin
		events.set_pulse = 19'h00000;
		events.set_pulse[BIT_DATA_DONE] = data_done_in;
		events.set_pulse[BIT_DATA_CRC] = data_crc_fail_in;
		events.set_pulse[BIT_RESP] = resp_ready_in;
		events.set_pulse[BIT_RESP_CRC] = resp_crc_fail_in;
		events.set_pulse[BIT_CMD_DONE] = cmd_sent_in;
		events.set_pulse[BIT_BUSY_END] = busy_end_in;
		events.set_pulse[BIT_TX_POP_ERR] = tx_card_err_in;
		events.set_pulse[BIT_RX_PUSH_ERR] = rx_card_err_in;
		events.set_pulse[BIT_BUS_POP_ERR] = rx_bus_err_in;
		events.set_pulse[BIT_BUS_PUSH_ERR] = bus_push_err;
		events.line3_level = line3_level;
		events.card_irq_level = card_irq_level;
	end

	// Each flag bit is a sticky event, a live level, or not built here
	genvar gi;
	for (gi = 0; gi < MASK_W; gi++) begin : g_flag
		if (gi == BIT_CARD_IRQ) begin : g_card
			assign next_flags[gi] = events.card_irq_level;
		end else if (gi == BIT_LINE3_LOW) begin : g_low
			assign next_flags[gi] = data_idle_in & ~events.line3_level;
		end else if (gi == BIT_LINE3_HIGH) begin : g_high
			assign next_flags[gi] = data_idle_in & events.line3_level;
		end else if (gi < BIT_BUS_PUSH_ERR) begin : g_unbuilt
			// FIFO level flags belong to the FIFO block and read as zero
			assign next_flags[gi] = 1'b0;
		end else begin : g_event
			assign next_flags[gi] = (flags[gi] & ~clear_req[gi]) | events.set_pulse[gi];
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_flags) begin
			next_prdata = {12'h000, events.line3_level, flags};
		end else if (hit_mask) begin
			next_prdata = {13'h0000, mask};
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			flags <= RAW_FLAGS_RESET[18:0];
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mask <= IRQ_MASK_RESET;
		end else if (wr_access & hit_mask) begin
			mask <= pwdata_in[MASK_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			byte_lane <= LANE_ZERO;
			last_size <= SIZE_WORD;
			size_seen <= 1'b0;
		end else if (tx_fifo_write_in) begin
			byte_lane <= byte_lane + size_bytes;
			last_size <= tx_fifo_size_in;
			size_seen <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in & ~penable_in & ~pwrite_in) begin
			prdata_out <= next_prdata;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(next_flags & ~mask);
		end
	end

	assign pready_out = 1'b1;
	// Writes to the read-only flag word or unmapped words are refused
	assign pslverr_out = access_phase & (~hit_any | (pwrite_in & hit_flags)
		| (rd_access & hit_clear));
endmodule
`default_nettype wire

/* File: card_irq_pkg.sv */
// Register map, field positions and reset values of the card host interrupt source block.
// Assumes a 32-bit APB slave with byte addresses.
package card_irq_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] RAW_FLAGS_OFFSET = 12'h000;
	localparam logic [11:0] IRQ_MASK_OFFSET = 12'h004;
	localparam logic [11:0] IRQ_CLEAR_OFFSET = 12'h008;
	localparam logic [11:0] WIDTH_CTRL_OFFSET = 12'h03c;
	localparam int FLAG_W = 20;
	localparam int MASK_W = 19;
	localparam int BIT_LINE3 = 19;
	localparam int BIT_CARD_IRQ = 18;
	localparam int BIT_DATA_DONE = 17;
	localparam int BIT_DATA_CRC = 16;
	localparam int BIT_RESP = 15;
	localparam int BIT_RESP_CRC = 14;
	localparam int BIT_LINE3_LOW = 13;
	localparam int BIT_LINE3_HIGH = 12;
	localparam int BIT_CMD_DONE = 11;
	localparam int BIT_BUSY_END = 10;
	localparam int BIT_TX_POP_ERR = 9;
	localparam int BIT_RX_PUSH_ERR = 8;
	localparam int BIT_BUS_POP_ERR = 7;
	localparam int BIT_BUS_PUSH_ERR = 6;
	localparam logic [31:0] RAW_FLAGS_RESET = 32'h0000_0000;
	localparam logic [18:0] IRQ_MASK_RESET = 19'h7ffff;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] LANE_ZERO = 2'h0;
endpackage

/* File: card_irq_event_if.sv */
// Bundle of one-cycle event pulses and live levels that feed the flag register.
// Assumes every signal is already in the system clock domain.
`timescale 1ns/1ns
`default_nettype none
interface card_irq_event_if;
	logic [18:0] set_pulse;
	logic line3_level;
	logic card_irq_level;
	modport source (output set_pulse, output line3_level, output card_irq_level);
	modport sink (input set_pulse, input line3_level, input card_irq_level);
endinterface
`default_nettype wire

/* File: card_irq_sync.sv */
// Two-flop synchroniser bank for levels arriving from card pins.
// Assumes the inputs are asynchronous to sys_clk_in.
`timescale 1ns/1ns
`default_nettype none
module card_irq_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// A zero-wide bank would leave the first stage without a driver
	if (WIDTH < 1) begin : g_bad_width
		$error("card_irq_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule
`default_nettype wire

/* File: card_irq_checker.sv */
// Concurrent checks on the ports of the interrupt source block.
// Assumes it is bound onto card_host_irq_source with a single clock.
`timescale 1ns/1ns
`default_nettype none
module card_irq_checker
	import card_irq_pkg::*;
(
	// All ports of the watched block
	input wire logic sys_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in, prdata_out,
	input wire logic pready_out, pslverr_out, card_data_line_three_in, card_irq_level_in,
	input wire logic data_done_in, data_crc_fail_in, resp_ready_in, resp_crc_fail_in,
	input wire logic cmd_sent_in, busy_end_in, tx_card_err_in, rx_card_err_in,
	input wire logic rx_bus_err_in, tx_bus_overrun_in, tx_fifo_write_in,
	input wire logic [1:0] tx_fifo_size_in,
	input wire logic data_idle_in, irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic [31:0] ev = {14'h0, data_done_in, data_crc_fail_in, resp_ready_in,
		resp_crc_fail_in, 2'h0, cmd_sent_in, busy_end_in, tx_card_err_in, rx_card_err_in,
		rx_bus_err_in, tx_bus_overrun_in, 6'h0};
	wire logic acc = psel_in && penable_in;
	wire logic rd = psel_in && !penable_in && !pwrite_in && paddr_in == RAW_FLAGS_OFFSET;
	wire logic wr_mask = acc && pwrite_in && paddr_in == IRQ_MASK_OFFSET;
	wire logic wr_clr = acc && pwrite_in && paddr_in == IRQ_CLEAR_OFFSET;
	wire logic [2:0] pins = {card_data_line_three_in, card_irq_level_in, data_idle_in};
	logic [2:0] prev;
	logic [1:0] calm;
	logic [18:0] mask;
	// Pins pass two sync flops, so only trust reads after they sat still
	always_ff @(posedge sys_clk_in) begin
		prev <= pins;
		calm <= (sys_rst_in || pins != prev) ? 2'h0 : calm + {1'b0, calm != 2'h3};
		mask <= sys_rst_in ? IRQ_MASK_RESET : (wr_mask ? pwdata_in[18:0] : mask);
	end
	a_ready_always: assert property (pready_out) else $error("pready low");
	a_raw_write_refused: assert property (acc && pwrite_in && paddr_in == RAW_FLAGS_OFFSET
		|-> pslverr_out) else $error("raw write taken");
	a_reset_irq_low: assert property ($fell(sys_rst_in) |-> !irq_out) else $error("irq");
	a_event_read_back: assert property ((|ev) ##2 rd |=>
		(prdata_out & $past(ev, 3)) == $past(ev, 3)) else $error("flag lost");
	a_reserved_zero: assert property (rd |=> prdata_out[31:20] == 12'h0) else $error("rsv");
	a_clear_works: assert property (wr_clr && !(|ev) ##1 !(|ev) && !tx_fifo_write_in ##1 rd
		|=> (prdata_out & $past(pwdata_in, 3) & 32'h0003_cfc0) == 32'h0)
		else $error("clr");
	a_masked_quiet: assert property (wr_mask && pwdata_in[18:0] == IRQ_MASK_RESET
		|-> ##2 !irq_out) else $error("masked irq");
	a_unmasked_irq: assert property ((|(ev[18:0] & ~mask)) && !wr_mask ##1 !acc
		|=> irq_out) else $error("no irq");
	a_pins_live: assert property (rd && calm == 2'h3 |=>
		prdata_out[19:18] == $past(pins[2:1]) && prdata_out[13:12] ==
		{$past(pins[0] && !pins[2]), $past(pins[0] && pins[2])}) else $error("pins");
	c_irq: cover property ($rose(irq_out));
	c_clear: cover property (wr_clr);
	c_refused: cover property (pslverr_out);
endmodule
bind card_host_irq_source card_irq_checker chk (.*);
`default_nettype wire

/* File: card_model.sv */
// Card on the far side: drives line 3 and the card interrupt level.
// Assumes the bench requests levels; each lands after a chosen lag.
`timescale 1ns/1ns
`default_nettype none
module card_model (
	// Clock
	input wire logic sys_clk_in,
	// Requested levels and lag in cycles
	input wire logic line3_in, irq_in,
	input wire logic [3:0] lag_in,
	// Card pins
	output logic line3_out, irq_out
);
	// Line 3 idles high through its pull-up
	initial begin
		line3_out = 1'b1;
		irq_out = 1'b0;
	end
	always @(line3_in or irq_in) begin
		repeat (lag_in) @(posedge sys_clk_in);
		line3_out <= line3_in;
		irq_out <= irq_in;
	end
endmodule
`default_nettype wire

/* File: card_host_irq_source_tb.sv */
// Self-checking bench for the interrupt source block.
// Assumes the checker is bound in and the card model drives the pins.
`timescale 1ns/1ns
`default_nettype none
module card_host_irq_source_tb;
	import card_irq_pkg::*;
	logic sys_clk_in = '0, sys_rst_in = 1'h1, psel_in = '0, penable_in = '0, pwrite_in = '0;
	logic [ADDR_W-1:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out, rd_val;
	logic pready_out, pslverr_out, slv, line3_in = 1'h1, irq_in = '0, line3, cirq, irq_out;
	logic tx_fifo_write_in = '0, data_idle_in = '0;
	logic [1:0] tx_fifo_size_in = '0;
	logic [3:0] lag = '0;
	logic [9:0] ev = '0;
	int err_total = 0, n_tests = 0, i, b, m;
	card_host_irq_source dut (.*, .card_data_line_three_in(line3), .card_irq_level_in(cirq),
		.data_done_in(ev[9]), .data_crc_fail_in(ev[8]), .resp_ready_in(ev[7]),
		.resp_crc_fail_in(ev[6]), .cmd_sent_in(ev[5]), .busy_end_in(ev[4]),
		.tx_card_err_in(ev[3]), .rx_card_err_in(ev[2]), .rx_bus_err_in(ev[1]),
		.tx_bus_overrun_in(ev[0]));
	card_model card (.sys_clk_in, .line3_in, .irq_in, .lag_in(lag), .line3_out(line3),
		.irq_out(cirq));
	always #10 sys_clk_in = ~sys_clk_in;
	function automatic int bit_of(input int k);
		return k >= 6 ? k + 8 : k + 6;
	endfunction
	function automatic logic [31:0] exp_pins(input logic l, input logic c);
		return {12'h0, l, c, 4'h0, !l, l, 12'h0};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'h1;
		do @(posedge sys_clk_in); while (pready_out !== 1'h1);
		rd_val = prdata_out;
		slv = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic strobe(input int k, input logic f, input logic [1:0] s);
		@(posedge sys_clk_in);
		if (f) tx_fifo_write_in <= 1'h1; else ev[k] <= 1'h1;
		tx_fifo_size_in <= s;
		@(posedge sys_clk_in);
		tx_fifo_write_in <= 1'h0;
		ev <= '0;
	endtask
	task automatic wrap_up;
		if (err_total == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		void'($urandom(7521));
		repeat (4) @(posedge sys_clk_in);
		sys_rst_in <= 1'h0;
		repeat (4) @(posedge sys_clk_in);
		apb(0, RAW_FLAGS_OFFSET, 0);
		chk("raw", 32'h0008_0000, rd_val);
		apb(0, IRQ_MASK_OFFSET, 0);
		chk("mask", 32'h0007_ffff, rd_val);
		apb(1, RAW_FLAGS_OFFSET, 0);
		chk("raw_wr", 32'h1, {31'h0, slv});
		apb(0, IRQ_CLEAR_OFFSET, 0);
		chk("clr_rd", 32'h1, {31'h0, slv});
		apb(0, 12'h00c, 0);
		chk("unmapped", 32'h1, {31'h0, slv});
		for (i = 0; i < 40; i++) begin
			b = i < 10 ? i : $urandom % 10;
			m = $urandom % 2;
			apb(1, IRQ_MASK_OFFSET, m ? 32'h7ffff : ~(32'h1 << bit_of(b)) & 32'h7ffff);
			strobe(b, 1'h0, SIZE_BYTE);
			apb(0, RAW_FLAGS_OFFSET, 0);
			chk("flag", 32'h1 << bit_of(b), rd_val & 32'h3cfc0);
			chk("irq", {31'h0, m == 0}, {31'h0, irq_out});
			apb(1, IRQ_CLEAR_OFFSET, 32'h1 << bit_of(b));
			apb(0, RAW_FLAGS_OFFSET, 0);
			chk("cleared", 0, rd_val & 32'h3cfc0);
			chk("irq_off", 0, {31'h0, irq_out});
		end
		data_idle_in <= 1'h1;
		for (i = 0; i < 4; i++) begin
			lag <= 4'($urandom % 8);
			line3_in <= i[0];
			irq_in <= i[1];
			repeat (14) @(posedge sys_clk_in);
			apb(1, IRQ_CLEAR_OFFSET, 32'h0004_0000);
			apb(0, RAW_FLAGS_OFFSET, 0);
			chk("pins", exp_pins(i[0], i[1]), rd_val & 32'h000c_3000);
		end
		strobe(0, 1'h1, SIZE_BYTE);
		apb(1, IRQ_CLEAR_OFFSET, 32'h40);
		strobe(0, 1'h1, SIZE_BYTE);
		apb(0, RAW_FLAGS_OFFSET, 0);
		chk("same_size", 0, rd_val & 32'h40);
		strobe(0, 1'h1, SIZE_WORD);
		apb(0, RAW_FLAGS_OFFSET, 0);
		chk("misalign", 32'h40, rd_val & 32'h40);
		wrap_up();
	end
endmodule
`default_nettype wire
